// File: remap_pkg.sv
// constants for the graphics aperture remap table
package remap_pkg;
    // ----------------------------------------
    // register offsets (byte address; word index = byte address / 4)
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TBL_ADDR = 8'h0C;
    localparam logic [7:0] REG_TBL_DATA = 8'h10;
    localparam logic [7:0] REG_MISS_CNT = 8'h14;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_BIG = 1;
    localparam int CTRL_SIZE_LO = 2;
    localparam int CTRL_INV_ERR = 4;
    localparam int CTRL_SRAM_PRESENT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // aperture size codes
    localparam logic [1:0] SIZE_256M = 2'h0;
    localparam logic [1:0] SIZE_1G = 2'h1;
    localparam logic [1:0] SIZE_32G = 2'h2;
    // ----------------------------------------
    // entry layout
    // ----------------------------------------
    localparam int ENT_PARITY = 26;
    localparam int ENT_COHERENT = 25;
    localparam int ENT_VALID = 24;
    localparam int OFS_SMALL = 12;
    localparam int OFS_BIG = 22;
    localparam int BASE_ZERO_HI = 27;
    localparam int BASE_ZERO_LO = 12;
    // ----------------------------------------
    // address widths and table memory latency
    // ----------------------------------------
    localparam int VA_W = 40;
    localparam int PA_W = 36;
    localparam int TBL_AW = 18;
    localparam int SRAM_LAT = 3;
endpackage

// File: table_sram.sv
// pipelined table memory: read data two edges after the address edge
module table_sram
    import remap_pkg::*;
#(
    parameter int AW = TBL_AW
) (
    input wire logic clock,
    input wire logic [AW-1:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    logic [31:0] mem [0:(1<<AW)-1];
    logic [31:0] stage1_ff;
    logic [31:0] stage2_ff;

    // ----------------------------------------
    // storage and output pipeline
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
        if (rd) begin
            stage1_ff <= mem[addr];
        end
        stage2_ff <= stage1_ff;
        rdata <= stage2_ff;
    end
endmodule

// File: remap_table.sv
// aperture remap unit: table lookup, translation and table programming
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module remap_table
    import remap_pkg::*;
#(
    parameter int AW = TBL_AW
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [VA_W-1:0] req_addr,
    output logic out_valid,
    output logic [VA_W-1:0] out_addr,
    output logic out_coherent,
    output logic out_translated,
    output logic err_invalid,
    output logic err_parity
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [VA_W-1:0] base_ff, nxt_base;
    logic [AW-1:0] tbl_addr_ff, nxt_tbl_addr;
    logic [1:0] status_ff, nxt_status;
    logic [15:0] miss_ff, nxt_miss;
    logic [31:0] rdata_ff, nxt_rdata;

    logic big;
    logic [1:0] size_code;
    assign big = ctrl_ff[CTRL_BIG];
    assign size_code = ctrl_ff[CTRL_SIZE_LO +: 2];

    // ----------------------------------------
    // lookup pipeline (no translation caching)
    // ----------------------------------------
    logic [SRAM_LAT-1:0] pv_ff, nxt_pv;
    logic [SRAM_LAT-1:0] phit_ff, nxt_phit;
    logic [VA_W-1:0] pa_ff [SRAM_LAT];
    logic [VA_W-1:0] nxt_pa [SRAM_LAT];
    logic [SRAM_LAT-1:0] prd_ff, nxt_prd;

    logic [VA_W-1:0] limit;
    logic [VA_W-1:0] off;
    logic in_ap;
    logic [AW-1:0] page_idx;
    logic [31:0] sram_rdata;
    logic [AW-1:0] sram_addr;
    logic sram_rd, sram_wr;
    logic [31:0] sram_wdata;
    logic ent_ok, ent_par_bad;

    always_comb begin
        unique case (size_code)
            SIZE_1G: limit = 40'h00_4000_0000;
            SIZE_32G: limit = big ? 40'h08_0000_0000 : 40'h00_1000_0000;
            default: limit = 40'h00_1000_0000;
        endcase
    end

    assign off = req_addr - base_ff;
    assign in_ap = ctrl_ff[CTRL_EN] && ctrl_ff[CTRL_SRAM_PRESENT] && req_addr >= base_ff
        && off < limit;
    assign page_idx = big ? AW'(off >> OFS_BIG) : AW'(off >> OFS_SMALL);

    // software table access wins a collision; the colliding lookup passes untranslated
    logic sw_wr, sw_rd;
    assign sw_wr = reg_wr && reg_addr == REG_TBL_DATA;
    assign sw_rd = reg_rd && reg_addr == REG_TBL_DATA;
    assign sram_wr = sw_wr;
    assign sram_rd = (req_valid && in_ap) || sw_rd;
    assign sram_addr = (req_valid && in_ap && !sw_wr && !sw_rd) ? page_idx : tbl_addr_ff;
    assign sram_wdata = {5'h00, ^{5'h00, reg_wdata[25:0]}, reg_wdata[25:0]};

    table_sram #(.AW(AW)) u_mem (
        .clock(clock),
        .addr(sram_addr),
        .rd(sram_rd),
        .wr(sram_wr),
        .wdata(sram_wdata),
        .rdata(sram_rdata)
    );

    assign ent_ok = sram_rdata[ENT_VALID];
    assign ent_par_bad = ^sram_rdata;

    always_comb begin
        nxt_pv = {pv_ff[SRAM_LAT-2:0], req_valid};
        nxt_phit = {phit_ff[SRAM_LAT-2:0], req_valid && in_ap && !sw_wr && !sw_rd};
        nxt_prd = {prd_ff[SRAM_LAT-2:0], sw_rd};
        nxt_pa[0] = req_addr;
        for (int i = 1; i < SRAM_LAT; i++) begin
            nxt_pa[i] = pa_ff[i-1];
        end
    end

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    logic ov_ff, nxt_ov;
    logic [VA_W-1:0] oa_ff, nxt_oa;
    logic oc_ff, nxt_oc, ot_ff, nxt_ot, ei_ff, nxt_ei, ep_ff, nxt_ep;
    logic [VA_W-1:0] va;
    assign va = pa_ff[SRAM_LAT-1];

    always_comb begin
        nxt_ov = pv_ff[SRAM_LAT-1];
        nxt_oa = va;
        nxt_oc = 1'b1;
        nxt_ot = 1'b0;
        nxt_ei = 1'b0;
        nxt_ep = 1'b0;
        if (phit_ff[SRAM_LAT-1]) begin
            nxt_ep = ent_par_bad;
            if (ent_ok) begin
                nxt_ot = 1'b1;
                nxt_oc = sram_rdata[ENT_COHERENT];
                if (big) begin
                    nxt_oa = {4'h0, sram_rdata[23:10], va[OFS_BIG-1:0]};
                end else begin
                    nxt_oa = {4'h0, sram_rdata[23:0], va[OFS_SMALL-1:0]};
                end
            end else begin
                nxt_ei = ctrl_ff[CTRL_INV_ERR];
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_base = base_ff;
        nxt_tbl_addr = tbl_addr_ff;
        nxt_status = status_ff;
        nxt_miss = miss_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_rd && reg_addr == REG_STATUS) begin
            nxt_status = 2'h0;
        end
        // set wins over read-clear
        nxt_status = nxt_status | {nxt_ep, nxt_ei};
        if (nxt_ov && !nxt_ot) begin
            nxt_miss = miss_ff + 16'h0001;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL: nxt_ctrl = {26'h0, reg_wdata[5:0]};
                REG_BASE: begin
                    nxt_base = {8'h00, reg_wdata};
                    nxt_base[BASE_ZERO_HI:BASE_ZERO_LO] = 16'h0000;
                end
                REG_TBL_ADDR: nxt_tbl_addr = reg_wdata[AW-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: nxt_rdata = ctrl_ff;
                REG_BASE: nxt_rdata = base_ff[31:0];
                REG_STATUS: nxt_rdata = {30'h0, status_ff};
                REG_TBL_ADDR: nxt_rdata = {{(32-AW){1'b0}}, tbl_addr_ff};
                REG_MISS_CNT: nxt_rdata = {16'h0, miss_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // table reads return three cycles later; data stays in the table word register
    logic [31:0] tbl_word_ff, nxt_tbl_word;
    always_comb begin
        nxt_tbl_word = tbl_word_ff;
        if (prd_ff[SRAM_LAT-1]) begin
            nxt_tbl_word = sram_rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff <= CTRL_RESET;
            base_ff <= '0;
            tbl_addr_ff <= '0;
            status_ff <= 2'h0;
            miss_ff <= 16'h0000;
            rdata_ff <= 32'h0000_0000;
            pv_ff <= '0;
            phit_ff <= '0;
            prd_ff <= '0;
            for (int i = 0; i < SRAM_LAT; i++) begin
                pa_ff[i] <= '0;
            end
            ov_ff <= 1'b0;
            oa_ff <= '0;
            oc_ff <= 1'b0;
            ot_ff <= 1'b0;
            ei_ff <= 1'b0;
            ep_ff <= 1'b0;
            tbl_word_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            base_ff <= nxt_base;
            tbl_addr_ff <= nxt_tbl_addr;
            status_ff <= nxt_status;
            miss_ff <= nxt_miss;
            rdata_ff <= nxt_rdata;
            pv_ff <= nxt_pv;
            phit_ff <= nxt_phit;
            prd_ff <= nxt_prd;
            pa_ff <= nxt_pa;
            ov_ff <= nxt_ov;
            oa_ff <= nxt_oa;
            oc_ff <= nxt_oc;
            ot_ff <= nxt_ot;
            ei_ff <= nxt_ei;
            ep_ff <= nxt_ep;
            tbl_word_ff <= nxt_tbl_word;
        end
    end

    // table data register reads the last fetched word; others read one cycle later
    logic tbl_rd_last_ff;
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tbl_rd_last_ff <= 1'b0;
        end else begin
            tbl_rd_last_ff <= sw_rd;
        end
    end
    assign reg_rdata = tbl_rd_last_ff ? tbl_word_ff : rdata_ff;

    assign out_valid = ov_ff;
    assign out_addr = oa_ff;
    assign out_coherent = oc_ff;
    assign out_translated = ot_ff;
    assign err_invalid = ei_ff;
    assign err_parity = ep_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n_ff);

    outside_pass_a: assert property (req_valid && !in_ap |-> ##4 out_valid && !out_translated
        && out_addr == $past(req_addr, 4)) else $error("outside address altered");
    disabled_pass_a: assert property (!ctrl_ff[CTRL_SRAM_PRESENT] && out_valid |-> !out_translated)
        else $error("translation without table");
    base_zero_a: assert property (base_ff[27:12] == 16'h0000) else $error("base low bits set");
    write_parity_a: assert property (sram_wr |-> ^sram_wdata == 1'b0) else $error("odd parity written");
    latency_a: assert property (req_valid |-> ##4 out_valid) else $error("lookup latency wrong");
    invalid_err_a: assert property (err_invalid |-> !out_translated && ctrl_ff[CTRL_INV_ERR])
        else $error("invalid error misflagged");
    small_ofs_a: assert property (out_translated && !big |-> out_addr[11:0] == $past(req_addr[11:0], 4))
        else $error("page offset lost");
    miss_pass_a: assert property (out_valid && !out_translated |-> out_addr == $past(req_addr, 4))
        else $error("miss not passed through");
    invalid_log_a: assert property (err_invalid |-> status_ff[0]) else $error("invalid event not logged");
    parity_log_a: assert property (err_parity |-> status_ff[1]) else $error("parity event not logged");

    hit_c: cover property (out_valid && out_translated);
    miss_c: cover property (err_invalid);
    par_c: cover property (err_parity);
    big_c: cover property (out_translated && big);
endmodule

// File: gfx_card.sv
// graphics card model issuing addresses to the remap unit
module gfx_card (
    input wire logic clock,
    output logic req_valid,
    output logic [39:0] req_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_valid = 1'b0;
        req_addr = 40'h00_0000_0000;
    end
    // one address per cycle, back to back allowed
    task automatic send(input logic [39:0] a);
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr <= a;
    endtask
    // released bus shows the inverse so a stale address cannot pass
    task automatic idle();
        @(posedge clock);
        req_valid <= 1'b0;
        req_addr <= ~req_addr;
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the aperture remap unit
module testbench
    import remap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [39:0] AP = 40'h00_8000_0000;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic req_valid;
    logic [VA_W-1:0] req_addr;
    logic out_valid, out_coherent, out_translated, err_invalid, err_parity;
    logic [VA_W-1:0] out_addr;
    logic [31:0] rv;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int rq[$];
    int oq[$];
    logic [39:0] aq[$];
    logic [3:0] fq[$];
    always #25 clock = ~clock;
    remap_table #(.AW(TBL_AW)) uut (
        .clock(clock),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .req_valid(req_valid),
        .req_addr(req_addr),
        .out_valid(out_valid),
        .out_addr(out_addr),
        .out_coherent(out_coherent),
        .out_translated(out_translated),
        .err_invalid(err_invalid),
        .err_parity(err_parity)
    );
    gfx_card card (
        .clock(clock),
        .req_valid(req_valid),
        .req_addr(req_addr)
    );
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (req_valid === 1'b1) rq.push_back(cyc);
        if (out_valid === 1'b1) begin
            oq.push_back(cyc);
            aq.push_back(out_addr);
            fq.push_back({out_coherent, out_translated, err_invalid, err_parity});
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // fixed wait: table word lands three edges after the first read
    task automatic rdtbl(input logic [31:0] i, output logic [31:0] d);
        wr(REG_TBL_ADDR, i);
        rd(REG_TBL_DATA, d);
        repeat (SRAM_LAT + 1) @(posedge clock);
        rd(REG_TBL_DATA, d);
    endtask
    function automatic logic [31:0] par(input logic [31:0] d);
        logic [31:0] e;
        e = d & 32'hFBFF_FFFF;
        return e | ({31'h0000_0000, ^e} << ENT_PARITY);
    endfunction
    // mask m picks the flags that matter: coherent, translated, invalid, parity
    task automatic expect_out(input logic [39:0] a, input logic [3:0] f, input logic [3:0] m);
        int n;
        n = 0;
        while (oq.size() == 0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (oq.size() == 0) begin
            mismatches++;
            give_verdict();
        end else begin
            chk(aq.pop_front(), a);
            chk({36'h0_0000_0000, fq.pop_front() & m}, {36'h0_0000_0000, f & m});
            chk(40'(oq.pop_front() - rq.pop_front()), 40'h00_0000_0004);
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (5) @(posedge clock);
        chk({39'h00_0000_0000, out_valid}, 40'h00_0000_0000);
        wr(REG_BASE, 32'hFFFF_FFFF);
        rd(REG_BASE, rv);
        chk({8'h00, rv & 32'h0FFF_F000}, 40'h00_0000_0000);
        rd(8'h3C, rv);
        chk({8'h00, rv}, 40'h00_0000_0000);
        wr(REG_BASE, 32'h8000_0000);
        wr(REG_CTRL, 32'h0000_0031);
        wr(REG_TBL_ADDR, 32'h0000_0006);
        wr(REG_TBL_DATA, 32'h0000_1111);
        wr(REG_TBL_ADDR, 32'h0000_0005);
        wr(REG_TBL_DATA, par(32'h03AB_CDEF) ^ 32'h0400_0000);
        rdtbl(32'h0000_0005, rv);
        chk({8'h00, rv}, {8'h00, par(32'h03AB_CDEF)});
        card.send(AP + 40'h00_0000_5123);
        card.send(40'h12_3456_7890);
        card.send(AP + 40'h00_0000_6ABC);
        card.idle();
        expect_out(40'h0A_BCDE_F123, 4'hC, 4'hF);
        expect_out(40'h12_3456_7890, 4'h0, 4'h7);
        expect_out(AP + 40'h00_0000_6ABC, 4'h2, 4'h7);
        rd(REG_STATUS, rv);
        chk({8'h00, rv & 32'h0000_0003}, 40'h00_0000_0001);
        rd(REG_STATUS, rv);
        chk({8'h00, rv & 32'h0000_0003}, 40'h00_0000_0000);
        wr(REG_TBL_DATA, 32'h0112_3456);
        rdtbl(32'h0000_0005, rv);
        chk({8'h00, rv}, {8'h00, par(32'h0112_3456)});
        card.send(AP + 40'h00_0000_5123);
        card.idle();
        expect_out(40'h01_2345_6123, 4'h4, 4'hF);
        wr(REG_CTRL, 32'h0000_0037);
        wr(REG_TBL_ADDR, 32'h0000_0001);
        wr(REG_TBL_DATA, 32'h01A9_7000);
        rdtbl(32'h0000_0001, rv);
        chk({8'h00, rv}, {8'h00, par(32'h01A9_7000)});
        card.send(AP + 40'h00_0041_2345);
        card.idle();
        expect_out({4'h0, 14'h2A5C, 22'h01_2345}, 4'h4, 4'hF);
        card.send(AP + 40'h00_4040_1234);
        card.idle();
        expect_out(AP + 40'h00_4040_1234, 4'h0, 4'h7);
        wr(REG_CTRL, 32'h0000_003B);
        wr(REG_TBL_ADDR, 32'h0000_0101);
        wr(REG_TBL_DATA, 32'h0300_0C00);
        rdtbl(32'h0000_0101, rv);
        chk({8'h00, rv}, {8'h00, par(32'h0300_0C00)});
        card.send(AP + 40'h00_4040_1234);
        card.idle();
        expect_out({4'h0, 14'h0003, 22'h00_1234}, 4'hC, 4'hF);
        wr(REG_CTRL, 32'h0000_0039);
        card.send(AP + 40'h00_1000_0000);
        card.idle();
        expect_out(AP + 40'h00_1000_0000, 4'h0, 4'h7);
        wr(REG_CTRL, 32'h0000_0011);
        card.send(AP + 40'h00_0000_5123);
        card.idle();
        expect_out(AP + 40'h00_0000_5123, 4'h0, 4'h7);
        rd(REG_MISS_CNT, rv);
        chk({8'h00, rv}, 40'h00_0000_0005);
        give_verdict();
    end
endmodule
